/* File: include/rtc_pkg.sv */
// Register map, field positions and reset values of the real-time clock block.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses.
package rtc_pkg;
    localparam int          ADDR_W          = 32;
    localparam int          DATA_W          = 32;
    localparam int          SEC_W           = 29;
    localparam int          DIV_W           = 15;
    localparam logic [31:0] ADDR_CONTROL    = 32'he000c000;
    localparam logic [31:0] ADDR_ALARM      = 32'he000c004;
    localparam logic [31:0] ADDR_COUNT      = 32'he000c008;
    localparam logic [31:0] ADDR_DIVIDER    = 32'he000c00c;
    localparam logic [31:0] ADDR_INT_STATUS = 32'he000c010;
    localparam logic [31:0] ADDR_INT_ENABLE = 32'he000c014;
    localparam int          CTL_CS_BIT      = 0;
    localparam int          CTL_IE_BIT      = 1;
    localparam int          CTL_BYP_BIT     = 4;
    localparam int          CTL_ENA_BIT     = 7;
    localparam logic [1:0]  CTL_RSVD_ONES   = 2'h3;
    localparam logic        CTL_CS_RESET    = 1'h1;
    localparam logic        CTL_IE_RESET    = 1'h0;
    localparam logic        CTL_BYP_RESET   = 1'h0;
    localparam logic        CTL_ENA_RESET   = 1'h1;
    localparam int          UCP_BIT         = 31;
    localparam int          INT_AI_BIT      = 0;
    localparam int          INT_IWI_BIT     = 1;
    localparam int          INT_W           = 2;
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;
    localparam logic        CS_SYS_CLOCK    = 1'h1;
endpackage

/* File: include/rtc_count_if.sv */
// Carrier between the register front end and the divider/seconds counter.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface rtc_count_if;
    import rtc_pkg::*;
    logic              tick;
    logic              incr_en;
    logic              div_wr;
    logic [DIV_W-1:0]  div_wdata;
    logic              sec_wr;
    logic [SEC_W-1:0]  sec_wdata;
    logic [DIV_W-1:0]  div_value;
    logic [SEC_W-1:0]  sec_value;
    logic              sec_update;
    modport ctl (output tick, incr_en, div_wr, div_wdata, sec_wr, sec_wdata,
                 input div_value, sec_value, sec_update);
    modport cnt (input tick, incr_en, div_wr, div_wdata, sec_wr, sec_wdata,
                 output div_value, sec_value, sec_update);
endinterface
`default_nettype wire

/* File: hdl/rtc_counter.sv */
// Divider and seconds counter of the real-time clock.
// Assumes tick is a one-cycle pulse per input clock period, synchronous to aclk.
`timescale 1ns/1ps
`default_nettype none
module rtc_counter
    import rtc_pkg::*;
#(
    parameter int TICKS_PER_SEC = 32768
) (
    input  wire logic aclk,
    input  wire logic aresetn,
    rtc_count_if.cnt  cnt
);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICKS_PER_SEC - 1);

    logic [DIV_W-1:0] div_q;
    logic [DIV_W-1:0] div_d;
    logic [SEC_W-1:0] sec_q;
    logic [SEC_W-1:0] sec_d;
    logic             wrap;

    // Divider frozen whenever incrementing is gated off, except when a divider write loads it
    assign wrap  = cnt.incr_en && cnt.tick && (div_q == DIV_LAST);
    assign div_d = cnt.div_wr ? cnt.div_wdata :
                   (cnt.incr_en && cnt.tick) ? (wrap ? '0 : div_q + 1'b1) : div_q;
    assign sec_d = wrap ? sec_q + 1'b1 : (cnt.sec_wr ? cnt.sec_wdata : sec_q);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_q <= '0;
            sec_q <= '0;
        end else begin
            div_q <= div_d;
            sec_q <= sec_d;
        end
    end

    assign cnt.div_value  = div_q;
    assign cnt.sec_value  = sec_q;
    assign cnt.sec_update = wrap;
endmodule
`default_nettype wire

/* File: hdl/rtc_ctrl.sv */
// Real-time clock: AXI4-Lite registers, clock source selection, alarm and interrupt.
// Assumes the crystal pin input is already synchronous to aclk and slower than aclk/2.
//
// What this block does
// - Bypass set runs crystal across both pins; cleared takes CMOS clock on first pin
// - Divider advances only while increment gate is one, else holds
// - Increment gate resets to zero so counting starts disabled
// - Clock select picks crystal/CMOS clock or divided system clock
// - Alarm condition raised when alarm value equals seconds count
// - Alarm reaches processor only when enabled here and in interrupt controller
// - Alarm register clears on power-up and hardware reset only
// - Alarm value is 29 bits, upper three bits reserved
// - Seconds count register presents elapsed seconds
// - Flag set on read marks count invalid; software rereads until clear
// - Seconds count updates exactly once per second
// - Update flag at bit 31: one if update hit the read
// - Alarm status set on match, cleared by writing one
// - Divider write while incrementing is refused and sets illegal-write flag
`timescale 1ns/1ps
`default_nettype none
module rtc_ctrl
    import rtc_pkg::*;
#(
    parameter int SYS_DIV       = 16,
    parameter int TICKS_PER_SEC = 32768
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]        s_axi_awprot,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]        s_axi_arprot,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [DATA_W-1:0]      s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              rtc_xtal_in_pin,
    output logic                   rtc_xtal_out_pin,
    output logic                   rtc_xtal_out_oe_n,
    output logic                   oscillator_power_on,
    output logic                   irq
);
    localparam int SYS_DIV_W = $clog2(SYS_DIV + 1);
    localparam logic [SYS_DIV_W-1:0] SYS_LAST = SYS_DIV_W'(SYS_DIV - 1);

    function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old_v,
                                                input logic [DATA_W-1:0] new_v,
                                                input logic [3:0]        strb);
        logic [DATA_W-1:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    rtc_count_if cif ();

    // Control fields
    logic             cs_q;
    logic             ie_q;
    logic             byp_q;
    logic             ena_q;
    logic [SEC_W-1:0] alarm_q;
    logic [INT_W-1:0] status_q;
    logic [INT_W-1:0] status_d;
    logic [INT_W-1:0] enable_q;

    // Bus state
    logic              aw_have_q;
    logic              w_have_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [DATA_W-1:0] wdata_q;
    logic [3:0]        wstrb_q;
    logic              bvalid_q;
    logic [1:0]        bresp_q;
    logic              rvalid_q;
    logic [1:0]        rresp_q;
    logic [DATA_W-1:0] rdata_q;

    // Clock source
    logic                 xtal_prev_q;
    logic [SYS_DIV_W-1:0] sys_cnt_q;
    logic                 xtal_edge;
    logic                 sys_tick;

    // Decoded write
    logic              aw_ok;
    logic              w_ok;
    logic              wr_fire;
    logic [ADDR_W-1:0] wa;
    logic [DATA_W-1:0] wd;
    logic [3:0]        ws;
    logic [DATA_W-1:0] ctl_word;
    logic [DATA_W-1:0] ctl_new;
    logic [DATA_W-1:0] alarm_new;
    logic [DATA_W-1:0] count_new;
    logic [DATA_W-1:0] div_new;
    logic [DATA_W-1:0] en_new;
    logic              wr_ctl;
    logic              wr_alarm;
    logic              wr_count;
    logic              wr_div;
    logic              wr_stat;
    logic              wr_en;
    logic              wr_hit;
    logic              div_illegal;
    logic              sec_illegal;
    logic [INT_W-1:0]  w1c;
    logic [INT_W-1:0]  events;
    logic              alarm_match;

    // Decoded read
    logic              rd_fire;
    logic              rd_hit;
    logic [DATA_W-1:0] rd_word;
    logic [DATA_W-1:0] count_word;

    // Clock input: pin edge or divided system clock
    assign xtal_edge = rtc_xtal_in_pin && !xtal_prev_q;
    assign sys_tick  = (sys_cnt_q == SYS_LAST);
    assign cif.tick  = (cs_q == CS_SYS_CLOCK) ? sys_tick : xtal_edge;

    // Inverting amplifier drives the crystal only in crystal mode
    assign rtc_xtal_out_pin    = byp_q && ena_q && !rtc_xtal_in_pin;
    assign rtc_xtal_out_oe_n   = !(byp_q && ena_q);
    assign oscillator_power_on = ena_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            xtal_prev_q <= 1'b0;
            sys_cnt_q   <= '0;
        end else begin
            xtal_prev_q <= rtc_xtal_in_pin;
            sys_cnt_q   <= sys_tick ? '0 : sys_cnt_q + 1'b1;
        end
    end

    rtc_counter #(
        .TICKS_PER_SEC (TICKS_PER_SEC)
    ) u_counter (
        .aclk    (aclk),
        .aresetn (aresetn),
        .cnt     (cif)
    );

    // Write channel: address and data taken in either order
    assign s_axi_awready = !aw_have_q && !bvalid_q;
    assign s_axi_wready  = !w_have_q && !bvalid_q;
    assign aw_ok   = aw_have_q || (s_axi_awvalid && s_axi_awready);
    assign w_ok    = w_have_q || (s_axi_wvalid && s_axi_wready);
    assign wr_fire = aw_ok && w_ok && !bvalid_q;
    assign wa      = aw_have_q ? awaddr_q : s_axi_awaddr;
    assign wd      = w_have_q ? wdata_q : s_axi_wdata;
    assign ws      = w_have_q ? wstrb_q : s_axi_wstrb;

    assign wr_ctl   = wr_fire && (wa == ADDR_CONTROL);
    assign wr_alarm = wr_fire && (wa == ADDR_ALARM);
    assign wr_count = wr_fire && (wa == ADDR_COUNT);
    assign wr_div   = wr_fire && (wa == ADDR_DIVIDER);
    assign wr_stat  = wr_fire && (wa == ADDR_INT_STATUS);
    assign wr_en    = wr_fire && (wa == ADDR_INT_ENABLE);
    assign wr_hit   = wr_ctl || wr_alarm || wr_count || wr_div || wr_stat || wr_en;

    always_comb begin
        ctl_word = '0;
        ctl_word[CTL_CS_BIT]  = cs_q;
        ctl_word[CTL_IE_BIT]  = ie_q;
        ctl_word[CTL_BYP_BIT] = byp_q;
        ctl_word[CTL_BYP_BIT+2:CTL_BYP_BIT+1] = CTL_RSVD_ONES;
        ctl_word[CTL_ENA_BIT] = ena_q;
    end

    assign ctl_new   = merge(ctl_word, wd, ws);
    assign alarm_new = merge({{(DATA_W-SEC_W){1'b0}}, alarm_q}, wd, ws);
    assign count_new = merge({{(DATA_W-SEC_W){1'b0}}, cif.sec_value}, wd, ws);
    assign div_new   = merge({{(DATA_W-DIV_W){1'b0}}, cif.div_value}, wd, ws);
    assign en_new    = merge({{(DATA_W-INT_W){1'b0}}, enable_q}, wd, ws);

    // Divider write refused while running; count write refused as it is updated
    assign div_illegal = wr_div && ie_q;
    assign sec_illegal = wr_count && ie_q && cif.sec_update;
    assign cif.incr_en   = ie_q;
    assign cif.div_wr    = wr_div && !ie_q;
    assign cif.div_wdata = div_new[DIV_W-1:0];
    assign cif.sec_wr    = wr_count && !sec_illegal;
    assign cif.sec_wdata = count_new[SEC_W-1:0];

    // Set wins over a clear in the same cycle
    assign alarm_match = (alarm_q == cif.sec_value);
    assign events[INT_AI_BIT]  = alarm_match;
    assign events[INT_IWI_BIT] = div_illegal || sec_illegal;
    assign w1c      = (wr_stat && ws[0]) ? wd[INT_W-1:0] : '0;
    assign status_d = (status_q & ~w1c) | events;
    assign irq      = |(status_q & enable_q);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cs_q     <= CTL_CS_RESET;
            ie_q     <= CTL_IE_RESET;
            byp_q    <= CTL_BYP_RESET;
            ena_q    <= CTL_ENA_RESET;
            alarm_q  <= '0;
            status_q <= '0;
            enable_q <= '0;
        end else begin
            if (wr_ctl) begin
                cs_q  <= ctl_new[CTL_CS_BIT];
                ie_q  <= ctl_new[CTL_IE_BIT];
                byp_q <= ctl_new[CTL_BYP_BIT];
                ena_q <= ctl_new[CTL_ENA_BIT];
            end
            if (wr_alarm) begin
                alarm_q <= alarm_new[SEC_W-1:0];
            end
            if (wr_en) begin
                enable_q <= en_new[INT_W-1:0];
            end
            status_q <= status_d;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            awaddr_q  <= '0;
            wdata_q   <= '0;
            wstrb_q   <= '0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            aw_have_q <= aw_ok && !wr_fire;
            w_have_q  <= w_ok && !wr_fire;
            if (wr_fire) begin
                bvalid_q <= 1'b1;
                bresp_q  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp  = bresp_q;

    // Read channel: one-cycle answer after the address is taken
    assign s_axi_arready = !rvalid_q;
    assign rd_fire = s_axi_arvalid && s_axi_arready;
    assign count_word = {cif.sec_update, {(DATA_W-SEC_W-1){1'b0}}, cif.sec_value};
    assign rd_hit = (s_axi_araddr == ADDR_CONTROL) || (s_axi_araddr == ADDR_ALARM) ||
                    (s_axi_araddr == ADDR_COUNT) || (s_axi_araddr == ADDR_DIVIDER) ||
                    (s_axi_araddr == ADDR_INT_STATUS) || (s_axi_araddr == ADDR_INT_ENABLE);
    assign rd_word =
        (s_axi_araddr == ADDR_CONTROL)    ? ctl_word :
        (s_axi_araddr == ADDR_ALARM)      ? {{(DATA_W-SEC_W){1'b0}}, alarm_q} :
        (s_axi_araddr == ADDR_COUNT)      ? count_word :
        (s_axi_araddr == ADDR_DIVIDER)    ? {{(DATA_W-DIV_W){1'b0}}, cif.div_value} :
        (s_axi_araddr == ADDR_INT_STATUS) ? {{(DATA_W-INT_W){1'b0}}, status_q} :
        (s_axi_araddr == ADDR_INT_ENABLE) ? {{(DATA_W-INT_W){1'b0}}, enable_q} : '0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rresp_q  <= RESP_OKAY;
            rdata_q  <= '0;
        end else begin
            if (rd_fire) begin
                rvalid_q <= 1'b1;
                rresp_q  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
                rdata_q  <= rd_word;
            end else if (s_axi_rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp  = rresp_q;
    assign s_axi_rdata  = rdata_q;
endmodule
`default_nettype wire

/* File: tb/rtc_ctrl_sva.sv */
// Port-level checks of the real-time clock control block.
// Bound to rtc_ctrl from the testbench top; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module rtc_ctrl_sva
    import rtc_pkg::*;
(
    input wire logic              aclk,
    input wire logic              aresetn,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic [DATA_W-1:0] s_axi_rdata,
    input wire logic              s_axi_rvalid,
    input wire logic              s_axi_rready,
    input wire logic [1:0]        s_axi_bresp,
    input wire logic              s_axi_bvalid,
    input wire logic              s_axi_bready,
    input wire logic              rtc_xtal_in_pin,
    input wire logic              rtc_xtal_out_pin,
    input wire logic              rtc_xtal_out_oe_n,
    input wire logic              oscillator_power_on,
    input wire logic              irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire ar_take = s_axi_arvalid && s_axi_arready;
    chk_pin_release: assert property (rtc_xtal_out_oe_n |-> !rtc_xtal_out_pin)
        else $error("released pin not low");
    chk_pin_invert: assert property (!rtc_xtal_out_oe_n |-> rtc_xtal_out_pin != rtc_xtal_in_pin)
        else $error("driven pin not inverse of input");
    chk_osc_drive: assert property (!rtc_xtal_out_oe_n |-> oscillator_power_on)
        else $error("pin driven with oscillator off");
    chk_reset_state: assert property ($rose(aresetn) |-> oscillator_power_on && rtc_xtal_out_oe_n && !irq)
        else $error("wrong state after reset");
    chk_read_answer: assert property (ar_take |=> s_axi_rvalid)
        else $error("read not answered");
    chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    chk_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response not held");
    chk_alarm_width: assert property (ar_take && s_axi_araddr == ADDR_ALARM |=> s_axi_rdata[31:29] == 3'h0)
        else $error("alarm upper bits not zero");
    chk_count_rsvd: assert property (ar_take && s_axi_araddr == ADDR_COUNT |=> s_axi_rdata[30:29] == 2'h0)
        else $error("count reserved bits set");
    chk_ctl_ones: assert property (ar_take && s_axi_araddr == ADDR_CONTROL |=> s_axi_rdata[6:5] == 2'h3)
        else $error("control reserved bits not ones");
endmodule
`default_nettype wire

/* File: tb/host_pic_model.sv */
// Far side: interrupt controller gate and free-running CMOS clock on the pin.
// Pin period is six aclk cycles, well below aclk/2.
`timescale 1ns/1ps
`default_nettype none
module host_pic_model (
    input  wire logic aclk,
    input  wire logic irq,
    input  wire logic pic_en,
    output logic      cpu_irq,
    output logic      xtal_pin
);
    logic [2:0] ph_q = 3'h0;
    always @(posedge aclk) ph_q <= (ph_q == 3'h5) ? 3'h0 : ph_q + 3'h1;
    assign xtal_pin = ph_q < 3'h3;
    assign cpu_irq  = irq & pic_en;
endmodule
`default_nettype wire

/* File: tb/rtc_control_and_alarm_test.sv */
// Self-checking bench: AXI4-Lite master, result queues and a monitor.
// Runs the divider fast: two aclk per system-clock tick, six per pin tick, four ticks per second.
`timescale 1ns/1ps
`default_nettype none
module rtc_control_and_alarm_test;
    import rtc_pkg::*;
    logic        aclk = 1'h0, aresetn = 1'h0;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
    logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, pic_en = 1'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        rtc_xtal_in_pin, rtc_xtal_out_pin, rtc_xtal_out_oe_n, oscillator_power_on, irq, cpu_irq;
    int          fail_count = 0, n_tests = 0, seed = 32'hb9086454, i;
    logic [31:0] rq_d[$], rq_m[$];
    logic [1:0]  bq[$], rr[$];
    // Edges the master keeps bready/rready low, so that held answers get exercised
    int          ready_lag = 0;

    always #50 aclk = ~aclk;
    rtc_ctrl #(.SYS_DIV(2), .TICKS_PER_SEC(4)) DUT (.*);
    host_pic_model partner (.aclk(aclk), .irq(irq), .pic_en(pic_en), .cpu_irq(cpu_irq), .xtal_pin(rtc_xtal_in_pin));

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
            fail_count++;
        end
    endtask
    task automatic finish_test();
        $display("comparisons %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic timeout();
        fail_count++;
        finish_test();
    endtask
    task automatic idle(input int k);
        repeat (k) @(posedge aclk);
    endtask
    // Only the six mapped words answer OKAY
    function automatic logic [1:0] resp_of(input logic [31:0] a);
        if (a == ADDR_CONTROL || a == ADDR_ALARM || a == ADDR_COUNT || a == ADDR_DIVIDER ||
            a == ADDR_INT_STATUS || a == ADDR_INT_ENABLE) begin
            return RESP_OKAY;
        end
        return RESP_SLVERR;
    endfunction
    // Response expected before the request goes out, so the monitor never pops empty
    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
        int n;
        bq.push_back(r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= (ready_lag == 0);
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid && s_axi_bready) break;
            if (n + 1 >= ready_lag) s_axi_bready <= 1'h1;
        end
        s_axi_bready <= 1'h0;
        if (n == 100) timeout();
        @(posedge aclk);
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m);
        int n;
        rq_d.push_back(e);
        rq_m.push_back(m);
        rr.push_back(resp_of(a));
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= (ready_lag == 0);
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid && s_axi_rready) break;
            if (n + 1 >= ready_lag) s_axi_rready <= 1'h1;
        end
        s_axi_rready <= 1'h0;
        if (n == 100) timeout();
        @(posedge aclk);
    endtask

    // An answer with no note behind it counts against the run
    always @(posedge aclk) begin
        if (s_axi_rvalid === 1'h1 && s_axi_rready === 1'h1) begin
            if (rq_d.size() > 0) begin
                cmp(s_axi_rdata & rq_m.pop_front(), rq_d.pop_front());
                cmp({30'h0, s_axi_rresp}, {30'h0, rr.pop_front()});
            end else begin
                $display("mismatch at %0t: got %h expected %h", $time, s_axi_rdata, 32'h0);
                fail_count++;
            end
        end
        if (s_axi_bvalid === 1'h1 && s_axi_bready === 1'h1) begin
            if (bq.size() > 0) begin
                cmp({30'h0, s_axi_bresp}, {30'h0, bq.pop_front()});
            end else begin
                $display("mismatch at %0t: got %h expected %h", $time, s_axi_bresp, 2'h0);
                fail_count++;
            end
        end
    end

    initial begin
        logic [31:0] d;
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        rd(ADDR_CONTROL, 32'he1, 32'hffffffff);
        rd(ADDR_ALARM, 32'h0, 32'hffffffff);
        cmp({31'h0, rtc_xtal_out_oe_n}, 32'h1);
        wr(ADDR_CONTROL + 32'h40, 32'hffffffff, RESP_SLVERR);
        rd(ADDR_CONTROL + 32'h40, 32'h0, 32'hffffffff);
        $display("test reset done");
        d = $random(seed);
        ready_lag = 3;
        wr(ADDR_ALARM, d, RESP_OKAY);
        rd(ADDR_ALARM, d & 32'h1fffffff, 32'hffffffff);
        ready_lag = 0;
        wr(ADDR_ALARM, 32'h2, RESP_OKAY);
        wr(ADDR_INT_STATUS, 32'h3, RESP_OKAY);
        rd(ADDR_INT_STATUS, 32'h0, 32'h3);
        wr(ADDR_INT_ENABLE, 32'h1, RESP_OKAY);
        pic_en <= 1'h1;
        wr(ADDR_CONTROL, 32'he3, RESP_OKAY);
        for (i = 0; i < 300 && cpu_irq !== 1'h1; i++) @(posedge aclk);
        if (i == 300) timeout();
        rd(ADDR_INT_STATUS, 32'h1, 32'h1);
        pic_en <= 1'h0;
        idle(1);
        cmp({31'h0, cpu_irq}, 32'h0);
        wr(ADDR_INT_ENABLE, 32'h0, RESP_OKAY);
        cmp({31'h0, irq}, 32'h0);
        idle(10);
        wr(ADDR_INT_STATUS, 32'h1, RESP_OKAY);
        rd(ADDR_INT_STATUS, 32'h0, 32'h1);
        $display("test alarm done");
        wr(ADDR_DIVIDER, 32'h3, RESP_OKAY);
        rd(ADDR_INT_STATUS, 32'h2, 32'h2);
        wr(ADDR_CONTROL, 32'he1, RESP_OKAY);
        wr(ADDR_COUNT, 32'h5, RESP_OKAY);
        wr(ADDR_DIVIDER, 32'h0, RESP_OKAY);
        idle(40);
        rd(ADDR_COUNT, 32'h5, 32'hffffffff);
        rd(ADDR_DIVIDER, 32'h0, 32'hffffffff);
        $display("test hold done");
        // Ten seconds either way; the low two bits absorb tick phase
        for (i = 0; i < 2; i++) begin
            wr(ADDR_COUNT, 32'h0, RESP_OKAY);
            wr(ADDR_DIVIDER, 32'h0, RESP_OKAY);
            wr(ADDR_CONTROL, i ? 32'he2 : 32'he3, RESP_OKAY);
            idle(i ? 237 : 77);
            wr(ADDR_CONTROL, 32'he1, RESP_OKAY);
            rd(ADDR_COUNT, 32'h8, 32'hfffffffc);
        end
        $display("test rate done");
        wr(ADDR_CONTROL, 32'h90, RESP_OKAY);
        cmp({31'h0, rtc_xtal_out_oe_n}, 32'h0);
        cmp({31'h0, rtc_xtal_out_pin ^ rtc_xtal_in_pin}, 32'h1);
        wr(ADDR_CONTROL, 32'h10, RESP_OKAY);
        cmp({30'h0, oscillator_power_on, rtc_xtal_out_oe_n}, 32'h1);
        $display("test bypass done");
        aresetn <= 1'h0;
        idle(2);
        aresetn <= 1'h1;
        rd(ADDR_ALARM, 32'h0, 32'hffffffff);
        $display("test second reset done");
        finish_test();
    end
endmodule
bind rtc_ctrl rtc_ctrl_sva chk (.*);
`default_nettype wire
